// ==== hw/fsp_aligner.sv ====
module fsp_aligner
	import fsp_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [FSP_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [FSP_NUM_IN-1:0] frame_sync_pulse_input,
	input wire logic [FSP_NUM_IN-1:0] associated_ref_clock,
	output logic [FSP_NUM_OUT-1:0] output_pin,
	output logic aligned_output_clock,
	output logic aligned_output_pulse
);

	fsp_ctrl_t ctrl;
	fsp_rate_t rate;
	logic [15:0] channel_master_divider;
	logic [15:0] pulse_div;
	logic [15:0] pulse_width;
	logic [31:0] period_cnt;
	logic [31:0] period;
	logic [31:0] align_count;
	logic aligned;
	fsp_state_t state;
	fsp_state_t next_state;

	fsp_edge_t pulse_edge [FSP_NUM_IN];
	fsp_edge_t ref_edge [FSP_NUM_IN];

	logic sel_edge;
	logic ref_rise;
	logic align_evt;
	logic frame_sync_pulse_enable;

	logic [15:0] half_cnt;
	logic [15:0] pulse_cnt;
	logic [15:0] half_limit;
	logic half_wrap;
	logic out_rise;
	logic [15:0] next_pulse_cnt;

	logic setup;
	logic wr_access;
	logic hit;
	logic [31:0] next_prdata;

	// every pulse input and every reference runs through its own three-register edge sync
	genvar gi;
	generate
		for (gi = 0; gi < FSP_NUM_IN; gi++) begin : g_in
			fsp_edge_sync u_pulse (
				.clock(clock),
				.rst_n(rst_n),
				.pin(frame_sync_pulse_input[gi]),
				.edges(pulse_edge[gi])
			);
			fsp_edge_sync u_ref (
				.clock(clock),
				.rst_n(rst_n),
				.pin(associated_ref_clock[gi]),
				.edges(ref_edge[gi])
			);
		end
	endgenerate

	assign frame_sync_pulse_enable = ctrl.enable;

	// polarity picks the active edge of the chosen pulse input
	assign sel_edge = ctrl.falling ? pulse_edge[ctrl.in_sel].fall
		: pulse_edge[ctrl.in_sel].rise;
	assign ref_rise = ref_edge[ctrl.ref_sel].rise;

	// frame mode waits for the reference; sync mode uses the pulse itself
	assign align_evt = frame_sync_pulse_enable &&
		((ctrl.sync_mode && sel_edge) ||
		(!ctrl.sync_mode && state == FSP_ARMED && ref_rise));

	always_comb begin
		next_state = state;
		unique case (state)
			FSP_IDLE: begin
				if (frame_sync_pulse_enable && !ctrl.sync_mode && sel_edge) begin
					next_state = FSP_ARMED;
				end
			end
			FSP_ARMED: begin
				if (!frame_sync_pulse_enable || ctrl.sync_mode || ref_rise) begin
					next_state = FSP_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= FSP_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// a divider of zero would stall the clock, so it acts as one
	assign half_limit = (channel_master_divider == 16'h0000) ? 16'h0000
		: channel_master_divider - 16'h0001;
	assign half_wrap = (half_cnt == half_limit);
	assign out_rise = half_wrap && !aligned_output_clock;
	assign next_pulse_cnt = (pulse_cnt >= pulse_div - 16'h0001) ? 16'h0000
		: pulse_cnt + 16'h0001;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			half_cnt <= 16'h0000;
			aligned_output_clock <= 1'b0;
		end else if (align_evt) begin
			half_cnt <= 16'h0000;
			aligned_output_clock <= 1'b1;
		end else if (half_wrap) begin
			half_cnt <= 16'h0000;
			aligned_output_clock <= ~aligned_output_clock;
		end else begin
			half_cnt <= half_cnt + 16'h0001;
		end
	end

	// the pulse period is a whole number of output clock periods, so the
	// two stay integer related whatever rate the input pulse has
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pulse_cnt <= 16'h0000;
			aligned_output_pulse <= 1'b0;
		end else if (align_evt) begin
			pulse_cnt <= 16'h0000;
			aligned_output_pulse <= (pulse_width != 16'h0000);
		end else if (out_rise) begin
			pulse_cnt <= next_pulse_cnt;
			aligned_output_pulse <= (next_pulse_cnt < pulse_width);
		end
	end

	generate
		for (gi = 0; gi < FSP_NUM_OUT; gi++) begin : g_out
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					output_pin[gi] <= 1'b0;
				end else if (!ctrl.out_en[gi]) begin
					output_pin[gi] <= 1'b0;
				end else begin
					output_pin[gi] <= ctrl.out_role[gi] ? aligned_output_pulse
						: aligned_output_clock;
				end
			end
		end
	endgenerate

	// period of the chosen pulse in system cycles; for slow rates the count saturates, and a saturated count then stores a period of zero
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			period_cnt <= 32'h00000000;
			period <= 32'h00000000;
		end else if (sel_edge) begin
			period_cnt <= 32'h00000000;
			period <= period_cnt + 32'h00000001;
		end else if (period_cnt != 32'hFFFFFFFF) begin
			period_cnt <= period_cnt + 32'h00000001;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			aligned <= 1'b0;
		end else if (!frame_sync_pulse_enable) begin
			aligned <= 1'b0;
		end else if (align_evt) begin
			aligned <= 1'b1;
		end
	end

	// apb slave: no wait states, errors on unmapped or misaligned address
	assign setup = psel && !penable;
	assign wr_access = psel && penable && pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;

	always_comb begin
		hit = 1'b1;
		next_prdata = 32'h00000000;
		unique case (paddr)
			FSP_OFF_CTRL: next_prdata = {16'h0000, ctrl};
			FSP_OFF_RATE: next_prdata = {28'h0000000, rate};
			FSP_OFF_MASTER_DIV: next_prdata = {16'h0000, channel_master_divider};
			FSP_OFF_PULSE_DIV: next_prdata = {16'h0000, pulse_div};
			FSP_OFF_PULSE_WIDTH: next_prdata = {16'h0000, pulse_width};
			FSP_OFF_STATUS: begin
				next_prdata[FSP_STAT_ALIGNED] = aligned;
				next_prdata[FSP_STAT_ARMED] = (state == FSP_ARMED);
				next_prdata[FSP_STAT_OSC_FAULT] = 1'b0;
			end
			FSP_OFF_PERIOD: next_prdata = period;
			FSP_OFF_ALIGN_CNT: next_prdata = align_count;
			default: hit = 1'b0;
		endcase
	end

	// read data is caught in the setup cycle so it stands for the access
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h00000000;
		end else if (setup) begin
			prdata <= next_prdata;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= FSP_CTRL_RESET;
			rate <= FSP_RATE_RESET;
			channel_master_divider <= FSP_MASTER_DIV_RESET;
			pulse_div <= FSP_PULSE_DIV_RESET;
			pulse_width <= FSP_PULSE_WIDTH_RESET;
		end else if (wr_access) begin
			unique case (paddr)
				FSP_OFF_CTRL: begin
					ctrl <= pwdata[FSP_CTRL_W-1:0];
					ctrl.rsvd <= 1'b0;
				end
				FSP_OFF_RATE: rate <= fsp_rate_t'(pwdata[3:0]);
				FSP_OFF_MASTER_DIV: channel_master_divider <= pwdata[15:0];
				FSP_OFF_PULSE_DIV: pulse_div <= pwdata[15:0];
				FSP_OFF_PULSE_WIDTH: pulse_width <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	// a write clears the count; an alignment in that cycle still counts
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			align_count <= 32'h00000000;
		end else if (wr_access && paddr == FSP_OFF_ALIGN_CNT) begin
			align_count <= align_evt ? 32'h00000001 : 32'h00000000;
		end else if (align_evt) begin
			align_count <= align_count + 32'h00000001;
		end
	end

	property p_sync_align;
		@(posedge clock) disable iff (!rst_n)
		(ctrl.enable && ctrl.sync_mode && sel_edge)
			|=> aligned_output_clock && half_cnt == 16'h0000;
	endproperty
	a_sync_align: assert property (p_sync_align)
		else $error("sync edge did not restart output clock");

	property p_frame_arm;
		@(posedge clock) disable iff (!rst_n)
		(ctrl.enable && !ctrl.sync_mode && sel_edge && state == FSP_IDLE)
			|=> state == FSP_ARMED;
	endproperty
	a_frame_arm: assert property (p_frame_arm)
		else $error("frame edge did not arm alignment");

	property p_frame_wait;
		@(posedge clock) disable iff (!rst_n)
		(state == FSP_IDLE && !ctrl.sync_mode) |-> !align_evt;
	endproperty
	a_frame_wait: assert property (p_frame_wait)
		else $error("frame alignment before reference edge");

	property p_frame_fire;
		@(posedge clock) disable iff (!rst_n)
		(state == FSP_ARMED && ctrl.enable && !ctrl.sync_mode && ref_rise)
			|=> aligned_output_clock && state == FSP_IDLE && aligned;
	endproperty
	a_frame_fire: assert property (p_frame_fire)
		else $error("reference edge did not align outputs");

	property p_disabled_quiet;
		@(posedge clock) disable iff (!rst_n)
		!ctrl.enable |=> !aligned && $stable(align_count) || $past(wr_access);
	endproperty
	a_disabled_quiet: assert property (p_disabled_quiet)
		else $error("alignment while disabled");

	property p_polarity;
		@(posedge clock) disable iff (!rst_n)
		(ctrl.sync_mode && ctrl.falling && pulse_edge[ctrl.in_sel].rise)
			|-> !align_evt;
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("wrong pulse edge used for alignment");

	property p_pulse_on_align;
		@(posedge clock) disable iff (!rst_n)
		(align_evt && pulse_width != 16'h0000) |=> aligned_output_pulse
			##1 (aligned_output_pulse || $past(out_rise) || $past(align_evt));
	endproperty
	a_pulse_on_align: assert property (p_pulse_on_align)
		else $error("output pulse missing after alignment");

	property p_pin_route;
		@(posedge clock) disable iff (!rst_n)
		(ctrl.out_en[0] && ctrl.out_role[0])
			|=> output_pin[0] == $past(aligned_output_pulse);
	endproperty
	a_pin_route: assert property (p_pin_route)
		else $error("pulse not routed to selected pin");

	property p_count;
		@(posedge clock) disable iff (!rst_n)
		(align_evt && !wr_access) |=> align_count == $past(align_count) + 1;
	endproperty
	a_count: assert property (p_count)
		else $error("alignment count did not advance");

	property p_falling_align;
		@(posedge clock) disable iff (!rst_n)
		(ctrl.enable && ctrl.sync_mode && ctrl.falling
			&& pulse_edge[ctrl.in_sel].fall) |-> align_evt;
	endproperty
	a_falling_align: assert property (p_falling_align)
		else $error("falling sync edge did not align");

	// a disabled channel must drop a pending frame arm at once
	property p_disabled_idle;
		@(posedge clock) disable iff (!rst_n)
		!ctrl.enable |=> state == FSP_IDLE;
	endproperty
	a_disabled_idle: assert property (p_disabled_idle)
		else $error("alignment stayed armed while disabled");

endmodule : fsp_aligner

// ==== hw/fsp_pkg.sv ====
package fsp_pkg;

	localparam int unsigned FSP_NUM_IN = 4;
	localparam int unsigned FSP_NUM_OUT = 4;
	localparam int unsigned FSP_ADDR_W = 8;

	localparam logic [7:0] FSP_OFF_CTRL = 8'h00;
	localparam logic [7:0] FSP_OFF_RATE = 8'h04;
	localparam logic [7:0] FSP_OFF_MASTER_DIV = 8'h08;
	localparam logic [7:0] FSP_OFF_PULSE_DIV = 8'h0C;
	localparam logic [7:0] FSP_OFF_PULSE_WIDTH = 8'h10;
	localparam logic [7:0] FSP_OFF_STATUS = 8'h14;
	localparam logic [7:0] FSP_OFF_PERIOD = 8'h18;
	localparam logic [7:0] FSP_OFF_ALIGN_CNT = 8'h1C;

	// control word, bit 15 down to bit 0
	typedef struct packed {
		logic [3:0] out_en;
		logic [3:0] out_role;
		logic [1:0] ref_sel;
		logic [1:0] in_sel;
		logic rsvd;
		logic falling;
		logic sync_mode;
		logic enable;
	} fsp_ctrl_t;

	localparam int unsigned FSP_CTRL_W = 16;
	localparam fsp_ctrl_t FSP_CTRL_RESET = 16'h0000;

	typedef enum logic [3:0] {
		FSP_RATE_PULSE_PER_EVEN_SECOND,
		FSP_RATE_1PPS,
		FSP_RATE_5PPS,
		FSP_RATE_10PPS,
		FSP_RATE_50HZ,
		FSP_RATE_100HZ,
		FSP_RATE_1KHZ,
		FSP_RATE_2KHZ,
		FSP_RATE_4KHZ,
		FSP_RATE_8KHZ
	} fsp_rate_t;

	localparam fsp_rate_t FSP_RATE_RESET = FSP_RATE_1PPS;

	localparam logic [15:0] FSP_MASTER_DIV_RESET = 16'h0001;
	localparam logic [15:0] FSP_PULSE_DIV_RESET = 16'h0008;
	localparam logic [15:0] FSP_PULSE_WIDTH_RESET = 16'h0001;

	localparam int unsigned FSP_STAT_ALIGNED = 0;
	localparam int unsigned FSP_STAT_ARMED = 1;
	localparam int unsigned FSP_STAT_OSC_FAULT = 31;

	typedef struct packed {
		logic rise;
		logic fall;
	} fsp_edge_t;

	typedef enum logic {
		FSP_IDLE,
		FSP_ARMED
	} fsp_state_t;

endpackage : fsp_pkg

// ==== hw/fsp_edge_sync.sv ====
module fsp_edge_sync
	import fsp_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic pin,
	output fsp_edge_t edges
);

	logic meta;
	logic stable;
	logic last;

	// meta is read by stable alone; edges come from the later stages
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta <= 1'b0;
			stable <= 1'b0;
			last <= 1'b0;
		end else begin
			meta <= pin;
			stable <= meta;
			last <= stable;
		end
	end

	assign edges.rise = stable & ~last;
	assign edges.fall = ~stable & last;

	property p_rise_single;
		@(posedge clock) disable iff (!rst_n)
		edges.rise |=> !edges.rise && !edges.fall;
	endproperty
	a_rise_single: assert property (p_rise_single)
		else $error("edge pulse lasted more than one cycle");

endmodule : fsp_edge_sync

// ==== dv/fsp_rx_model.sv ====
module fsp_rx_model (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic aligned_output_clock,
	input wire logic aligned_output_pulse,
	output logic [15:0] rx_period,
	output logic [7:0] rx_pulses
);
	timeunit 1ns;
	timeprecision 1ns;
	logic last_clk;
	logic last_pls;
	logic [15:0] cnt;
	logic [15:0] next_cnt;
	// a clock rise on the same edge as the pulse rise closes the period,
	// so the count does not depend on pulse-to-clock skew
	always_comb next_cnt = cnt + 16'(aligned_output_clock & ~last_clk);
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			last_clk <= 1'b0;
			last_pls <= 1'b0;
			cnt <= 16'h0000;
			rx_period <= 16'h0000;
			rx_pulses <= 8'h00;
		end else begin
			last_clk <= aligned_output_clock;
			last_pls <= aligned_output_pulse;
			cnt <= next_cnt;
			if (aligned_output_pulse && !last_pls) begin
				rx_period <= next_cnt;
				rx_pulses <= rx_pulses + 8'h01;
				cnt <= 16'h0000;
			end
		end
	end
endmodule : fsp_rx_model

// ==== dv/frame_sync_pulse_aligner_tb.sv ====
module frame_sync_pulse_aligner_tb;
	import fsp_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [FSP_ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [FSP_NUM_IN-1:0] fpin = '0;
	logic [FSP_NUM_IN-1:0] rclk = '0;
	logic [FSP_NUM_OUT-1:0] opin;
	logic oclk;
	logic opls;
	logic [15:0] rx_period;
	logic [7:0] rx_pulses;
	int fail_count = 0;
	int checks = 0;
	logic [31:0] d;
	logic [31:0] rnd;
	logic err;
	logic pc;
	logic pp;
	logic [1:0] k;
	logic [1:0] j;
	int n;
	int i;
	int b;
	fsp_ctrl_t cw;
	always #50 clock = ~clock;
	fsp_aligner fsp_aligner_inst (.clock(clock), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .frame_sync_pulse_input(fpin),
		.associated_ref_clock(rclk), .output_pin(opin),
		.aligned_output_clock(oclk), .aligned_output_pulse(opls));
	fsp_rx_model fsp_rx_model_inst (.clock(clock), .rst_n(rst_n),
		.aligned_output_clock(oclk), .aligned_output_pulse(opls),
		.rx_period(rx_period), .rx_pulses(rx_pulses));
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		// only the watchdog ends a wait for the slave
		while (pready !== 1'b1) begin
			@(posedge clock);
		end
		d = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask : apb
	function automatic logic [31:0] ctl(input logic en, input logic sm,
		input logic fa, input logic [1:0] is, input logic [1:0] rs,
		input logic [7:0] pins);
		return {16'h0000, pins, rs, is, 1'b0, fa, sm, en};
	endfunction : ctl
	function automatic logic pin_exp(logic en, logic role, logic c, logic p);
		return en ? (role ? p : c) : 1'b0;
	endfunction : pin_exp
	task end_sim;
		$display("checks=%0d mismatches=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_sim
	initial begin
		#3000000;
		fail_count++;
		end_sim();
	end
	initial begin
		rnd = $urandom(32'h559A);
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		apb(1'b0, FSP_OFF_CTRL, 32'h0);
		chk(d, 32'(FSP_CTRL_RESET));
		chk(32'(err), 32'h0);
		apb(1'b0, FSP_OFF_PULSE_WIDTH, 32'h0);
		chk(d, 32'(FSP_PULSE_WIDTH_RESET));
		apb(1'b0, FSP_OFF_MASTER_DIV, 32'h0);
		chk(d, 32'h1);
		apb(1'b0, FSP_OFF_PULSE_DIV, 32'h0);
		chk(d, 32'h8);
		apb(1'b0, FSP_OFF_STATUS, 32'h0);
		chk(32'(d[FSP_STAT_OSC_FAULT]), 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		chk({d[30:0], err}, 32'h1);
		for (n = 0; n < 10; n++) begin
			apb(1'b1, FSP_OFF_RATE, 32'(n));
			apb(1'b0, FSP_OFF_RATE, 32'h0);
			chk(d, 32'(n));
		end
		$display("test registers done");
		k = 2'($urandom_range(3, 0));
		apb(1'b1, FSP_OFF_MASTER_DIV, 32'h4);
		apb(1'b1, FSP_OFF_ALIGN_CNT, 32'h0);
		apb(1'b1, FSP_OFF_CTRL, ctl(1'b1, 1'b1, 1'b0, k, 2'h0, 8'h00));
		fpin[k] <= 1'b1;
		repeat (4) @(posedge clock);
		chk(32'({oclk, opls}), 32'h3);
		fpin[k] <= 1'b0;
		apb(1'b0, FSP_OFF_STATUS, 32'h0);
		chk(32'(d[FSP_STAT_ALIGNED]), 32'h1);
		n = $urandom_range(40, 10);
		fpin[k] <= 1'b1;
		repeat (4) @(posedge clock);
		fpin[k] <= 1'b0;
		repeat (n - 4) @(posedge clock);
		fpin[k] <= 1'b1;
		repeat (4) @(posedge clock);
		fpin[k] <= 1'b0;
		apb(1'b0, FSP_OFF_PERIOD, 32'h0);
		chk(d, 32'(n));
		apb(1'b0, FSP_OFF_ALIGN_CNT, 32'h0);
		chk(d, 32'h3);
		apb(1'b1, FSP_OFF_CTRL, ctl(1'b1, 1'b1, 1'b1, k, 2'h0, 8'h00));
		fpin[k] <= 1'b1;
		repeat (4) @(posedge clock);
		apb(1'b0, FSP_OFF_ALIGN_CNT, 32'h0);
		chk(d, 32'h3);
		fpin[k] <= 1'b0;
		repeat (4) @(posedge clock);
		chk(32'({oclk, opls}), 32'h3);
		apb(1'b1, FSP_OFF_CTRL, ctl(1'b0, 1'b1, 1'b0, k, 2'h0, 8'h00));
		fpin[k] <= 1'b1;
		repeat (4) @(posedge clock);
		fpin[k] <= 1'b0;
		apb(1'b0, FSP_OFF_ALIGN_CNT, 32'h0);
		chk(d, 32'h4);
		$display("test sync done");
		j = 2'($urandom_range(3, 0));
		apb(1'b1, FSP_OFF_CTRL, ctl(1'b1, 1'b0, 1'b0, k, j, 8'h00));
		fpin[k] <= 1'b1;
		repeat (5) @(posedge clock);
		// an unselected reference must not complete the alignment
		rclk[j + 2'd1] <= 1'b1;
		repeat (4) @(posedge clock);
		rclk[j + 2'd1] <= 1'b0;
		apb(1'b0, FSP_OFF_STATUS, 32'h0);
		chk(32'(d[FSP_STAT_ARMED]), 32'h1);
		apb(1'b0, FSP_OFF_ALIGN_CNT, 32'h0);
		chk(d, 32'h4);
		rclk[j] <= 1'b1;
		repeat (4) @(posedge clock);
		chk(32'({oclk, opls}), 32'h3);
		rclk[j] <= 1'b0;
		fpin[k] <= 1'b0;
		apb(1'b0, FSP_OFF_ALIGN_CNT, 32'h0);
		chk(d, 32'h5);
		$display("test frame done");
		n = $urandom_range(6, 2);
		rnd = $urandom;
		cw = 16'(ctl(1'b1, 1'b1, 1'b0, k, j, rnd[7:0]));
		apb(1'b1, FSP_OFF_PULSE_DIV, 32'(n));
		apb(1'b1, FSP_OFF_MASTER_DIV, 32'h2);
		apb(1'b1, FSP_OFF_CTRL, 32'(cw));
		for (i = 0; i < 30; i++) begin
			@(posedge clock);
			for (b = 0; b < FSP_NUM_OUT; b++) begin
				if (i > 0) begin
					rnd[0] = pin_exp(cw.out_en[b], cw.out_role[b], pc, pp);
					chk(32'(opin[b]), 32'(rnd[0]));
				end
			end
			pc = oclk;
			pp = opls;
		end
		b = rx_pulses + 2;
		i = 0;
		while (rx_pulses != 8'(b) && i < 2000) begin
			@(posedge clock);
			i++;
		end
		chk(32'(rx_pulses), 32'(8'(b)));
		chk(32'(rx_period), 32'(n));
		$display("test outputs done");
		end_sim();
	end
endmodule : frame_sync_pulse_aligner_tb
